/* caf_filter.sv */
// Chosen here: the address map and register access over APB.
`timescale 1ns/10ps

// Summary of operation
// - Acceptance testing starts only for frames flagged free of bit errors.
// - Ready centers tested in order 1 to 15; first pass takes the frame.
// - Five masks: standard, extended, center 15, media arbitration masks.
// - A center loads a frame only when all its enabled tests succeed.
// - Standard format compares 11 identifier bits, extended compares 29.
// - Identifier mask disabled means exact identifier match required.
// - Mask enabled compares only bits set in the format's global mask.
// - Center 15 masks with its own mask ANDed with the global mask.
// - Media mask enable adds matching of the first two data bytes.
// - Media bytes compare only where media mask bits are one.
// - Software sets direction of centers 1 to 14 and each center's 0 to 8 byte length.
// - Center 15 is receive only, with its own arbitration and mask.
// - After lost arbitration or error, reload lowest pending transmit center.
// - Receive interrupt enable makes a receipt set a software-cleared flag.
module caf_filter
  import caf_pkg::*;
#(
  parameter int NUM_CENTERS = 15
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_valid,
  input wire logic frame_error_free,
  input wire logic frame_ext,
  input wire logic [28:0] frame_id,
  input wire logic [3:0] frame_dlc,
  input wire logic [7:0] frame_data1,
  input wire logic [7:0] frame_data2,
  output logic filter_busy,
  output logic accept_valid,
  output logic [3:0] accept_center,
  input wire logic tx_retry,
  input wire logic tx_done,
  output logic tx_load_valid,
  output logic [3:0] tx_load_center,
  output logic [28:0] tx_load_id,
  output logic tx_load_ext,
  output logic irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    caf_state_t st;
    logic [3:0] idx;
    logic [28:0] rx_id;
    logic rx_ext;
    logic [3:0] rx_dlc;
    logic [15:0] rx_media;
    logic [10:0] std_mask;
    logic [28:0] ext_mask;
    logic [28:0] mc15_mask;
    logic [15:0] media_arb;
    logic [15:0] media_mask;
    logic [2:0] status;
    logic [2:0] irq_en;
    logic [NUM_CENTERS:1][28:0] arb;
    logic [NUM_CENTERS:1][7:0] fmt;
    logic [NUM_CENTERS:1][3:0] ctrl;
    logic [NUM_CENTERS:1][19:0] rxdata;
    logic [31:0] prdata;
    logic pslverr;
    logic acc_valid;
    logic [3:0] acc_center;
    logic tx_valid;
    logic [3:0] tx_center;
    logic [28:0] tx_id;
    logic tx_ext;
  } caf_regs_t;

  caf_regs_t s;
  caf_regs_t next_s;

  logic [3:0] wc;
  logic [3:0] ac;
  logic [28:0] eff_mask;
  logic [28:0] id_diff;
  logic id_ok;
  logic media_ok;
  logic fmt_ok;
  logic hit;
  logic [3:0] tx_sel;
  logic tx_found;
  logic center_irq;

  // ****************************************************************
  // Acceptance test of the center under scan
  // ****************************************************************
  always_comb begin
    ac = (s.idx == 4'h0) ? 4'h1 : s.idx;
    id_diff = (s.rx_id ^ s.arb[ac]) &
      (s.rx_ext ? CAF_MASK_RST : {18'h00000, 11'h7FF});
    if (!s.fmt[ac][CAF_FMT_IDME]) begin
      eff_mask = CAF_MASK_RST;
    end else if (s.rx_ext) begin
      eff_mask = s.ext_mask;
    end else begin
      eff_mask = {18'h00000, s.std_mask};
    end
    if (ac == 4'(NUM_CENTERS) && s.fmt[ac][CAF_FMT_IDME]) begin
      eff_mask = eff_mask & s.mc15_mask;
    end
    id_ok = ((id_diff & eff_mask) == 29'h00000000);
    fmt_ok = (s.fmt[ac][CAF_FMT_EXT] == s.rx_ext);
    media_ok = !s.fmt[ac][CAF_FMT_MEDIA_MASK_ENABLE] ||
      (((s.rx_media ^ s.media_arb) & s.media_mask) == 16'h0000);
    hit = s.ctrl[ac][CAF_CTRL_READY] && !s.fmt[ac][CAF_FMT_DIR] &&
      id_ok && fmt_ok && media_ok;
  end

  // ****************************************************************
  // Transmit reload priority pick
  // ****************************************************************
  always_comb begin
    tx_sel = 4'h1;
    tx_found = 1'b0;
    center_irq = 1'b0;
    for (int i = NUM_CENTERS; i >= 1; i--) begin
      if (s.ctrl[i][CAF_CTRL_READY] && s.ctrl[i][CAF_CTRL_TXPEND] &&
          s.fmt[i][CAF_FMT_DIR]) begin
        tx_sel = 4'(i);
        tx_found = 1'b1;
      end
      center_irq = center_irq | s.ctrl[i][CAF_CTRL_IRQ];
    end
  end

  // ****************************************************************
  // Next state: bus, scan and reload
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.acc_valid = 1'b0;
    next_s.tx_valid = 1'b0;
    wc = paddr[7:4];
    // Read data and error captured in the setup cycle
    if (psel && !penable) begin
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h00000000;
      if (paddr == CAF_STD_MASK) begin
        next_s.prdata = {21'h000000, s.std_mask};
      end else if (paddr == CAF_EXT_MASK) begin
        next_s.prdata = {3'h0, s.ext_mask};
      end else if (paddr == CAF_MC15_MASK) begin
        next_s.prdata = {3'h0, s.mc15_mask};
      end else if (paddr == CAF_MEDIA_ARB) begin
        next_s.prdata = {16'h0000, s.media_arb};
      end else if (paddr == CAF_MEDIA_MASK) begin
        next_s.prdata = {16'h0000, s.media_mask};
      end else if (paddr == CAF_STATUS) begin
        next_s.prdata = {29'h00000000, s.status};
      end else if (paddr == CAF_CLEAR) begin
        next_s.prdata = 32'h00000000;
      end else if (paddr == CAF_ENABLE) begin
        next_s.prdata = {29'h00000000, s.irq_en};
      end else if (paddr == CAF_INFO) begin
        next_s.prdata = {27'h0000000, s.st == CAF_SCAN, s.acc_center};
      end else if (paddr[11:8] == CAF_CENTER_PAGE && wc != 4'h0 &&
                   wc <= 4'(NUM_CENTERS) && paddr[1:0] == 2'h0) begin
        if (paddr[3:0] == CAF_C_ARB) begin
          next_s.prdata = {3'h0, s.arb[wc]};
        end else if (paddr[3:0] == CAF_C_FMT) begin
          next_s.prdata = {24'h000000, s.fmt[wc]};
        end else if (paddr[3:0] == CAF_C_CTRL) begin
          next_s.prdata = {28'h0000000, s.ctrl[wc]};
        end else begin
          next_s.prdata = {12'h000, s.rxdata[wc]};
        end
      end else begin
        next_s.pslverr = 1'b1;
      end
    end
    // Transmit completion drops the pending request
    if (tx_done) begin
      next_s.ctrl[s.tx_center][CAF_CTRL_TXPEND] = 1'b0;
    end
    // Register writes in the access cycle
    if (psel && penable && pwrite && !s.pslverr) begin
      if (paddr == CAF_STD_MASK) begin
        next_s.std_mask = pwdata[10:0];
      end else if (paddr == CAF_EXT_MASK) begin
        next_s.ext_mask = pwdata[28:0];
      end else if (paddr == CAF_MC15_MASK) begin
        next_s.mc15_mask = pwdata[28:0];
      end else if (paddr == CAF_MEDIA_ARB) begin
        next_s.media_arb = pwdata[15:0];
      end else if (paddr == CAF_MEDIA_MASK) begin
        next_s.media_mask = pwdata[15:0];
      end else if (paddr == CAF_CLEAR) begin
        next_s.status = s.status & ~pwdata[2:0];
      end else if (paddr == CAF_ENABLE) begin
        next_s.irq_en = pwdata[2:0];
      end else if (paddr[11:8] == CAF_CENTER_PAGE) begin
        if (paddr[3:0] == CAF_C_ARB) begin
          next_s.arb[wc] = pwdata[28:0];
        end else if (paddr[3:0] == CAF_C_FMT) begin
          next_s.fmt[wc] = pwdata[7:0];
          if (pwdata[7:4] > CAF_MAX_DLC) begin
            next_s.fmt[wc][7:4] = CAF_MAX_DLC;
          end
          if (wc == 4'(NUM_CENTERS)) begin
            next_s.fmt[wc][CAF_FMT_DIR] = 1'b0;
          end
        end else if (paddr[3:0] == CAF_C_CTRL) begin
          next_s.ctrl[wc] = pwdata[3:0];
        end
      end
    end
    // Frame scan
    case (s.st)
      CAF_IDLE: begin
        if (frame_valid && frame_error_free) begin
          next_s.st = CAF_SCAN;
          next_s.idx = 4'h1;
          next_s.rx_id = frame_id;
          next_s.rx_ext = frame_ext;
          next_s.rx_dlc = frame_dlc;
          next_s.rx_media = {frame_data1, frame_data2};
        end
      end
      CAF_SCAN: begin
        if (hit) begin
          next_s.st = CAF_IDLE;
          next_s.rxdata[ac] = {s.rx_dlc, s.rx_media};
          next_s.acc_valid = 1'b1;
          next_s.acc_center = ac;
          next_s.status[CAF_EV_ACCEPT] = 1'b1;
          if (s.ctrl[ac][CAF_CTRL_RXIE]) begin
            next_s.ctrl[ac][CAF_CTRL_IRQ] = 1'b1;
          end
        end else if (s.idx >= 4'(NUM_CENTERS)) begin
          next_s.st = CAF_IDLE;
          next_s.status[CAF_EV_DISCARD] = 1'b1;
        end else begin
          next_s.idx = s.idx + 4'h1;
        end
      end
      default: begin
        next_s.st = CAF_IDLE;
      end
    endcase
    // Transmit buffer reload
    if (tx_retry && tx_found) begin
      next_s.tx_valid = 1'b1;
      next_s.tx_center = tx_sel;
      next_s.tx_id = s.arb[tx_sel];
      next_s.tx_ext = s.fmt[tx_sel][CAF_FMT_EXT];
      next_s.status[CAF_EV_RELOAD] = 1'b1;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.std_mask <= CAF_MASK_RST[10:0];
      s.ext_mask <= CAF_MASK_RST;
      s.mc15_mask <= CAF_MASK_RST;
      s.media_mask <= CAF_MEDIA_MASK_RST;
      s.tx_center <= 4'h1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = s.prdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & s.pslverr;
  assign filter_busy = (s.st == CAF_SCAN);
  assign accept_valid = s.acc_valid;
  assign accept_center = s.acc_center;
  assign tx_load_valid = s.tx_valid;
  assign tx_load_center = s.tx_center;
  assign tx_load_id = s.tx_id;
  assign tx_load_ext = s.tx_ext;
  // Sticky events and center flags drive one level interrupt
  assign irq = (|(s.status & s.irq_en)) | center_irq;

endmodule

/* caf_pkg.sv */
package caf_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [11:0] CAF_STD_MASK = 12'h000;
  localparam logic [11:0] CAF_EXT_MASK = 12'h004;
  localparam logic [11:0] CAF_MC15_MASK = 12'h008;
  localparam logic [11:0] CAF_MEDIA_ARB = 12'h00C;
  localparam logic [11:0] CAF_MEDIA_MASK = 12'h010;
  localparam logic [11:0] CAF_STATUS = 12'h014;
  localparam logic [11:0] CAF_CLEAR = 12'h018;
  localparam logic [11:0] CAF_ENABLE = 12'h01C;
  localparam logic [11:0] CAF_INFO = 12'h020;
  localparam logic [3:0] CAF_CENTER_PAGE = 4'h1;
  localparam logic [3:0] CAF_C_ARB = 4'h0;
  localparam logic [3:0] CAF_C_FMT = 4'h4;
  localparam logic [3:0] CAF_C_CTRL = 4'h8;
  localparam logic [3:0] CAF_C_RXDATA = 4'hC;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CAF_FMT_MEDIA_MASK_ENABLE = 0;
  localparam int CAF_FMT_IDME = 1;
  localparam int CAF_FMT_EXT = 2;
  localparam int CAF_FMT_DIR = 3;
  localparam int CAF_FMT_DLC = 4;
  localparam int CAF_CTRL_READY = 0;
  localparam int CAF_CTRL_RXIE = 1;
  localparam int CAF_CTRL_IRQ = 2;
  localparam int CAF_CTRL_TXPEND = 3;
  localparam int CAF_EV_ACCEPT = 0;
  localparam int CAF_EV_DISCARD = 1;
  localparam int CAF_EV_RELOAD = 2;
  localparam int CAF_STD_BITS = 11;
  localparam int CAF_EXT_BITS = 29;
  localparam logic [3:0] CAF_MAX_DLC = 4'h8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [28:0] CAF_MASK_RST = 29'h1FFFFFFF;
  localparam logic [15:0] CAF_MEDIA_MASK_RST = 16'h0000;
  localparam logic [7:0] CAF_FMT_RST = 8'h00;
  localparam logic [3:0] CAF_CTRL_RST = 4'h0;

  typedef enum logic [0:0] {
    CAF_IDLE = 1'b0,
    CAF_SCAN = 1'b1
  } caf_state_t;

endpackage

/* caf_can_node.sv */
`timescale 1ns/10ps
// ****************************************
// Remote node frame source
// ****************************************
module caf_can_node (
  output logic frame_valid,
  output logic frame_error_free,
  output logic frame_ext,
  output logic [28:0] frame_id,
  output logic [3:0] frame_dlc,
  output logic [7:0] frame_data1,
  output logic [7:0] frame_data2,
  input wire logic pclk
);
  // Quiet lines until the first frame
  initial begin
    {frame_valid, frame_error_free, frame_ext} = 3'h0;
    {frame_id, frame_dlc, frame_data1, frame_data2} = '0;
  end
  // One cycle frame; afterwards all lines but frame_dlc flip so stale data is not seen
  task automatic send(logic ok, logic ext, logic [28:0] id, logic [15:0] d);
    @(posedge pclk);
    frame_valid <= 1'b1;
    frame_error_free <= ok;
    frame_ext <= ext;
    frame_id <= id;
    frame_dlc <= 4'h8;
    {frame_data1, frame_data2} <= d;
    @(posedge pclk);
    frame_valid <= 1'b0;
    frame_error_free <= ~ok;
    frame_ext <= ~ext;
    frame_id <= ~id;
    {frame_data1, frame_data2} <= ~d;
  endtask
endmodule

/* caf_filter_asserts.sv */
`timescale 1ns/10ps
// ****************************************
// Filter port checker
// ****************************************
module caf_filter_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_valid,
  input wire logic frame_error_free,
  input wire logic filter_busy,
  input wire logic accept_valid,
  input wire logic [3:0] accept_center,
  input wire logic tx_retry,
  input wire logic tx_load_valid,
  input wire logic [3:0] tx_load_center
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answer and scan timing
  a_pready_access: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_slverr_phase: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_frame_taken: assert property (frame_valid && frame_error_free
    && !filter_busy |=> filter_busy) else $error("clean frame not taken");
  a_bad_dropped: assert property (frame_valid && !frame_error_free
    && !filter_busy |=> !filter_busy) else $error("bad frame scanned");
  a_scan_bound: assert property ($rose(filter_busy)
    |-> ##[1:16] !filter_busy) else $error("scan too long");
  a_accept_ends: assert property (accept_valid
    |-> !filter_busy && $past(filter_busy) && accept_center != 4'h0)
    else $error("accept without scan");
  a_accept_pulse: assert property (accept_valid |=> !accept_valid)
    else $error("accept longer than one cycle");
  a_reload_cause: assert property (tx_load_valid
    |-> $past(tx_retry) && tx_load_center != 4'hF)
    else $error("reload without retry");
endmodule

bind caf_filter caf_filter_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .frame_valid(frame_valid), .frame_error_free(frame_error_free),
  .filter_busy(filter_busy), .accept_valid(accept_valid),
  .accept_center(accept_center), .tx_retry(tx_retry),
  .tx_load_valid(tx_load_valid), .tx_load_center(tx_load_center));

/* tb_top.sv */
`timescale 1ns/10ps
// ****************************************
// Acceptance filter bench
// ****************************************
module tb_top;
  import caf_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic tx_retry = 0, tx_done = 0, pready, pslverr, last_err, irq;
  logic frame_valid, frame_error_free, frame_ext, filter_busy;
  logic accept_valid, tx_load_valid, tx_load_ext;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_data;
  logic [28:0] frame_id, tx_load_id;
  logic [3:0] frame_dlc, accept_center, tx_load_center;
  logic [7:0] frame_data1, frame_data2;
  int fail_count = 0, tests_run = 0, seed = 32'h64FE75D2;
  int m_arb[16], m_fmt[16], m_rdy[16], m_msk[5];
  int exp_tx[3] = '{3, 7, 0};

  // Clock, design and remote node
  always #10 pclk = ~pclk;
  caf_filter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .frame_valid(frame_valid), .frame_error_free(frame_error_free),
    .frame_ext(frame_ext), .frame_id(frame_id), .frame_dlc(frame_dlc),
    .frame_data1(frame_data1), .frame_data2(frame_data2),
    .filter_busy(filter_busy), .accept_valid(accept_valid),
    .accept_center(accept_center), .tx_retry(tx_retry),
    .tx_done(tx_done), .tx_load_valid(tx_load_valid),
    .tx_load_center(tx_load_center), .tx_load_id(tx_load_id),
    .tx_load_ext(tx_load_ext));
  caf_can_node node (.pclk(pclk), .frame_valid(frame_valid),
    .frame_error_free(frame_error_free), .frame_ext(frame_ext),
    .frame_id(frame_id), .frame_dlc(frame_dlc),
    .frame_data1(frame_data1), .frame_data2(frame_data2));

  // Verdict, compare and bus cycle
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    rd_data = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic irq_is(logic exp);
    @(negedge pclk);
    chk(irq, exp);
  endtask
  function automatic logic [11:0] ca(int c, int off);
    return 12'h100 + 12'(c * 16 + off);
  endfunction

  // Reference acceptance: first ready receive center passing every test
  function automatic int exp_center(logic x, logic [28:0] id, logic [15:0] d);
    int m;
    for (int c = 1; c < 16; c++) begin
      m = x ? 32'h1FFFFFFF : 32'h7FF;
      if (m_fmt[c][1]) m = m & m_msk[x] & (c == 15 ? m_msk[2] : -1);
      if (m_rdy[c] != 0 && m_fmt[c][2] == x && !m_fmt[c][3] &&
          ((id ^ m_arb[c]) & m) == 0 &&
          (!m_fmt[c][0] || ((d ^ m_msk[3]) & m_msk[4]) == 0))
        return c;
    end
    return 0;
  endfunction
  task automatic frame(logic ok, logic x, logic [28:0] id, logic [15:0] d);
    int e;
    logic [31:0] got;
    e = ok ? exp_center(x, id, d) : 0;
    got = 0;
    node.send(ok, x, id, d);
    repeat (20) begin
      @(negedge pclk);
      if (accept_valid === 1'b1) got = {28'h0, accept_center};
    end
    chk(got, e);
    apb(1'b0, CAF_STATUS, 0);
    chk(rd_data, !ok ? 0 : (e != 0 ? 1 : 2));
  endtask

  // Main sequence
  initial begin
    int r, k;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CAF_STD_MASK, 0);
    chk(rd_data, 32'h7FF);
    apb(1'b0, CAF_EXT_MASK, 0);
    chk(rd_data, 32'h1FFFFFFF);
    apb(1'b0, CAF_MEDIA_MASK, 0);
    chk(rd_data, 0);
    apb(1'b0, 12'h030, 0);
    chk(rd_data, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    for (int rnd = 0; rnd < 3; rnd++) begin
      for (int i = 0; i < 5; i++) begin
        m_msk[i] = $random(seed) & (i == 0 ? 32'h7FF : i > 2 ? 32'hFFFF :
          32'h1FFFFFFF);
        apb(1'b1, 12'(i * 4), m_msk[i]);
      end
      for (int c = 1; c < 16; c++) begin
        r = $random(seed);
        m_arb[c] = r & 32'h1FFFFFFF;
        m_rdy[c] = r[31] | r[30];
        apb(1'b1, ca(c, 4), {24'h0, r[7:4], c == 15, r[2:0]});
        m_fmt[c] = {r[7:4] > 8 ? 4'h8 : r[7:4], 1'b0, r[2:0]};
        apb(1'b0, ca(c, 4), 0);
        chk(rd_data, m_fmt[c]);
        apb(1'b1, ca(c, 0), m_arb[c]);
        apb(1'b1, ca(c, 8), m_rdy[c]);
      end
      for (int f = 0; f < 16; f++) begin
        r = $random(seed);
        k = 1 + (r & 32'hF) % 15;
        frame(r[11] | r[12], m_fmt[k][2],
          m_arb[k] ^ (r[4] ? 29'h0 : 29'h1 << r[9:5]),
          r[10] ? m_msk[3] : $random(seed));
        apb(1'b1, CAF_CLEAR, 7);
      end
    end
    m_fmt[1] = 0;
    m_rdy[1] = 1;
    apb(1'b1, ca(1, 4), 0);
    apb(1'b1, ca(1, 8), 1);
    apb(1'b1, CAF_ENABLE, 1);
    frame(1'b1, 1'b0, m_arb[1], 0);
    irq_is(1'b1);
    apb(1'b1, CAF_ENABLE, 0);
    irq_is(1'b0);
    apb(1'b1, CAF_ENABLE, 1);
    irq_is(1'b1);
    apb(1'b1, CAF_CLEAR, 1);
    irq_is(1'b0);
    apb(1'b1, CAF_ENABLE, 0);
    apb(1'b1, ca(1, 8), 3);
    frame(1'b1, 1'b0, m_arb[1], 0);
    apb(1'b1, CAF_CLEAR, 7);
    irq_is(1'b1);
    apb(1'b0, ca(1, 8), 0);
    chk(rd_data, 7);
    apb(1'b0, ca(1, 12), 0);
    chk(rd_data, 32'h00080000);
    apb(1'b1, ca(1, 8), 3);
    irq_is(1'b0);
    foreach (exp_tx[i]) apb(1'b1, ca(i * 4 + 3 + (i / 2) * 4, 4), 8);
    foreach (exp_tx[i]) apb(1'b1, ca(i * 4 + 3 + (i / 2) * 4, 8), 9);
    foreach (exp_tx[i]) begin
      @(posedge pclk);
      tx_retry <= 1'b1;
      @(posedge pclk);
      tx_retry <= 1'b0;
      @(negedge pclk);
      chk(tx_load_valid, exp_tx[i] != 0);
      if (exp_tx[i] != 0) chk({tx_load_ext, tx_load_center, tx_load_id},
        {1'b0, 4'(exp_tx[i]), 29'(m_arb[exp_tx[i]])});
      @(posedge pclk);
      tx_done <= 1'b1;
      @(posedge pclk);
      tx_done <= 1'b0;
    end
    print_verdict();
  end
endmodule
